// ---- hdl/tbcl_defs.vh ----
`ifndef TBCL_DEFS_VH
`define TBCL_DEFS_VH

// Register word indices (Avalon word address)
`define TBCL_ADDR_CTRL 2'h0
`define TBCL_ADDR_VSEL 2'h1
`define TBCL_ADDR_STAT 2'h2
`define TBCL_ADDR_FREQ 2'h3

// Control register fields
`define TBCL_CTRL_EN_LSB 0
`define TBCL_CTRL_SKIP_LSB 3
`define TBCL_CTRL_GO_BIT 6
`define TBCL_CTRL_SYNC_BIT 7

// Reset values
`define TBCL_RST_CHAN_EN 3'h7
`define TBCL_RST_SKIP 3'h0
`define TBCL_RST_VSEL 7'h00
`define TBCL_RST_FREQ_HALF 16'h0014

// Voltage code decode: code n gives base plus n steps, in mV
`define TBCL_VCODE_BASE_MV 12'h2A8
`define TBCL_VCODE_MAX 7'h7F

// Counts in switching cycles
`define TBCL_OC_WAIT_CYC 9'h100
`define TBCL_HICCUP_CYC 14'h2000
`define TBCL_PG_RISE_CYC 10'h268
`define TBCL_PG_FALL_CYC 10'h070

// Positions in the synchronised pin vector
`define TBCL_PIN_ON 0
`define TBCL_PIN_OC 3
`define TBCL_PIN_OV 6
`define TBCL_PIN_BUV 9
`define TBCL_PIN_PG 12
`define TBCL_PIN_SSD 15
`define TBCL_PIN_OTT 18
`define TBCL_PIN_OTC 19
`define TBCL_PIN_SYNC 20
`define TBCL_PIN_SCL 21
`define TBCL_PIN_SDA 22
`define TBCL_PIN_W 23

`endif

// ---- hdl/tbcl_sync.v ----
`timescale 1ns/10ps
`default_nettype none

module tbcl_sync #(
	parameter W = 23
) (
	input wire clk_sys, // System clock
	input wire rstn, // Synchronous reset, active low
	input wire ce, // Clock enable
	input wire [W-1:0] d_in, // Asynchronous inputs
	output wire [W-1:0] d_out // Synchronised copy
);

	reg [W-1:0] s1_reg; // First stage, read only by second stage
	reg [W-1:0] s2_reg; // Second stage, safe to use

	// Two flops per bit; metastability settles in the first
	always @(posedge clk_sys) begin
		if (!rstn) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
		end else if (ce) begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
		end
	end

	assign d_out = s2_reg;

endmodule
`default_nettype wire

// ---- hdl/tbcl_top.v ----
// Function
// [RQ1] Overcurrent over 256 cycles: stop, wait 8192, restart
// [RQ2] Voltage change starts only after trigger command
// [RQ3] Channel two voltage from 7-bit code
// [RQ4] Both bus lines low: reject access, standalone
// [RQ5] Standalone: each channel follows own enable pin
// [RQ6] Host enables channels and reads status
// [RQ7] Power-good state readable by host
// [RQ8] Power-ok high: all in window, sequence done
// [RQ9] Continuous conduction default; skipping only when enabled
// [RQ10] Channel one clock opposite phase to others
// [RQ11] Cycle start aligned to external clock falling edge
// [RQ12] Overvoltage holds high-side switch off until cleared
// [RQ13] Thermal shutdown restarts through soft-start after cooling
// [RQ14] Bootstrap undervoltage pulls switch node low
// [RQ15] Trigger moves channel two to internal divider
// [RQ16] 128 codes, 0.68 V plus 10 mV steps
// [RQ17] Power-ok falling edge deglitched 112 cycles
// [RQ18] Power-ok rising edge deglitched 616 cycles
// [RQ19] Overcurrent wait count clears when overcurrent ends
// [RQ20] Hiccup restart goes through soft-start
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tbcl_defs.vh"

module tbcl_top #(
	parameter HICCUP_CYCLES = `TBCL_HICCUP_CYC
) (
	input wire clk_sys, // 20 MHz system clock
	input wire rstn, // Synchronous reset, active low
	input wire ce, // Clock enable, freezes all state when low
	input wire [1:0] avs_address, // Avalon word address
	input wire avs_read, // Avalon read request
	input wire avs_write, // Avalon write request
	input wire [31:0] avs_writedata, // Avalon write data
	input wire [3:0] avs_byteenable, // Avalon byte lanes
	output wire [31:0] avs_readdata, // Avalon read data
	output wire avs_waitrequest, // Avalon stall
	input wire [2:0] channel_on_input, // Per-channel enable pins
	input wire [2:0] oc_in, // Overcurrent comparators
	input wire [2:0] ov_in, // Feedback above 105 percent
	input wire [2:0] bst_uv_in, // Bootstrap undervoltage
	input wire [2:0] pg_in, // Channel within regulation window
	input wire [2:0] ss_done_in, // Soft-start finished
	input wire ot_trip_in, // Junction above trip point
	input wire ot_cool_in, // Junction cooled below hysteresis
	input wire sync_in, // External switching clock
	input wire scl_in, // Serial clock line sense
	input wire sda_in, // Serial data line sense
	output wire [2:0] ch_run, // Converter channel running
	output wire [2:0] ss_start, // Soft-start restart pulse
	output wire [2:0] hs_off, // High-side switch forced off
	output wire [2:0] switch_node_low, // Pull switch node low
	output wire [2:0] pulse_skip_setting, // Skip allowed per channel
	output wire [6:0] voltage_code, // Active channel two code
	output wire fb_internal, // Channel two on internal divider
	output wire sw_clk_ch1, // Channel one switching clock
	output wire sw_clk_ch23, // Channels two, three clock
	output wire power_ok_output // Power-good pin
);

	// One-hot channel states
	localparam ST_OFF = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_HIC = 3'b100;

	wire [`TBCL_PIN_W-1:0] pins_s; // Synchronised pins

	// Every pin crosses in from outside the clock domain
	tbcl_sync #(
		.W(`TBCL_PIN_W)
	) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		// Bus lines enter inverted so the flops' reset level reads as present
		.d_in({~sda_in, ~scl_in, sync_in, ot_cool_in, ot_trip_in, ss_done_in, pg_in,
			bst_uv_in, ov_in, oc_in, channel_on_input}),
		.d_out(pins_s)
	);

	wire [2:0] on_s = pins_s[`TBCL_PIN_ON +: 3]; // Enable pins
	wire [2:0] oc_s = pins_s[`TBCL_PIN_OC +: 3]; // Overcurrent
	wire [2:0] ov_s = pins_s[`TBCL_PIN_OV +: 3]; // Overvoltage
	wire [2:0] buv_s = pins_s[`TBCL_PIN_BUV +: 3]; // Bootstrap low
	wire [2:0] pg_s = pins_s[`TBCL_PIN_PG +: 3]; // In window
	wire [2:0] ssd_s = pins_s[`TBCL_PIN_SSD +: 3]; // Soft-start done
	wire ott_s = pins_s[`TBCL_PIN_OTT]; // Thermal trip
	wire otc_s = pins_s[`TBCL_PIN_OTC]; // Thermal cool
	wire sync_s = pins_s[`TBCL_PIN_SYNC]; // External clock
	wire scl_low_s = pins_s[`TBCL_PIN_SCL]; // Bus clock line low
	wire sda_low_s = pins_s[`TBCL_PIN_SDA]; // Bus data line low

	// Code n in millivolts: base plus ten per step
	function [11:0] code_to_mv;
		input [6:0] code;
		begin
			code_to_mv = `TBCL_VCODE_BASE_MV + {2'b00, code, 3'b000} + {4'b0000, code, 1'b0};
		end
	endfunction

	// Register file and bus state
	reg [2:0] chan_en_reg; // Host channel enables
	reg [2:0] skip_en_reg; // Host skip enables
	reg sync_sel_reg; // Follow external clock
	reg [6:0] vsel_reg; // Staged voltage code
	reg [6:0] vcode_reg; // Active voltage code
	reg fb_int_reg; // Internal divider selected
	reg [15:0] freq_half_reg; // Half switching period in clk_sys cycles
	reg bus_absent_reg; // Standalone operation
	reg [31:0] rdata_reg; // Read data
	reg waitreq_reg; // Waitrequest
	reg [2:0] skip_out_reg; // Skip setting to power stage

	wire req = avs_read | avs_write; // Any request
	wire acc = req & ~waitreq_reg; // Edge where request completes
	wire wr_acc = avs_write & acc & ~bus_absent_reg; // Write that lands

	// Switching clock state
	reg [15:0] hp_cnt_reg; // Half-period counter
	reg phase_reg; // Channels two, three phase
	reg ch1_clk_reg; // Channel one phase
	reg sync_d_reg; // Previous synchronised external clock
	reg tick_reg; // Switching cycle start strobe

	// Shared fault and power-good state
	reg ot_reg; // Thermal shutdown active
	reg pok_reg; // Power-good output
	reg [9:0] pg_cnt_reg; // Deglitch counter

	wire [2:0] run_w; // Per-channel running
	wire [2:0] oc_wait_w; // Overcurrent wait counting
	wire [2:0] hic_w; // Hiccup waiting

	// Floating or grounded bus lines both read low; note that a genuine
	// start condition never holds both low for long, but any low on
	// both, however brief, is read as absence, so keep presence sensing on idle lines
	always @(posedge clk_sys) begin
		if (!rstn) begin
			bus_absent_reg <= 1'b0;
		end else if (ce) begin
			bus_absent_reg <= scl_low_s & sda_low_s; // RQ4
		end
	end

	// Avalon slave: one wait state, then the accept edge
	always @(posedge clk_sys) begin
		if (!rstn) begin
			waitreq_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else if (ce) begin
			// Drop waitrequest for one cycle per request
			if (acc) begin
				waitreq_reg <= 1'b1;
			end else if (req) begin
				waitreq_reg <= 1'b0;
			end else begin
				waitreq_reg <= 1'b1;
			end
			// Load read data the cycle before acceptance
			if (avs_read & waitreq_reg) begin
				if (bus_absent_reg) begin
					rdata_reg <= 32'h00000000; // RQ4
				end else begin
					case (avs_address)
						`TBCL_ADDR_CTRL: begin
							rdata_reg <= {24'h000000, sync_sel_reg, 1'b0, skip_en_reg,
								chan_en_reg};
						end
						`TBCL_ADDR_VSEL: begin
							rdata_reg <= {4'h0, code_to_mv(vcode_reg), 8'h00, fb_int_reg,
								vsel_reg}; // RQ16
						end
						`TBCL_ADDR_STAT: begin
							// Host sees power-good and fault state
							rdata_reg <= {17'h00000, bus_absent_reg, ot_reg, hic_w, oc_wait_w,
								run_w, pok_reg, pg_s}; // RQ6 RQ7
						end
						`TBCL_ADDR_FREQ: begin
							rdata_reg <= {16'h0000, freq_half_reg};
						end
						default: begin
							rdata_reg <= 32'h00000000;
						end
					endcase
				end
			end
		end
	end

	// Register writes, byte lanes respected; GO is a strobe, not stored
	always @(posedge clk_sys) begin
		if (!rstn) begin
			chan_en_reg <= `TBCL_RST_CHAN_EN;
			skip_en_reg <= `TBCL_RST_SKIP;
			sync_sel_reg <= 1'b0;
			vsel_reg <= `TBCL_RST_VSEL;
			vcode_reg <= `TBCL_RST_VSEL;
			fb_int_reg <= 1'b0;
			freq_half_reg <= `TBCL_RST_FREQ_HALF;
		end else if (ce) begin
			if (bus_absent_reg) begin
				fb_int_reg <= 1'b0; // RQ4
			end
			if (wr_acc) begin
				case (avs_address)
					`TBCL_ADDR_CTRL: begin
						if (avs_byteenable[0]) begin
							chan_en_reg <= avs_writedata[`TBCL_CTRL_EN_LSB +: 3]; // RQ6
							skip_en_reg <= avs_writedata[`TBCL_CTRL_SKIP_LSB +: 3]; // RQ9
							sync_sel_reg <= avs_writedata[`TBCL_CTRL_SYNC_BIT];
							// Transition only on the trigger command
							if (avs_writedata[`TBCL_CTRL_GO_BIT]) begin
								vcode_reg <= vsel_reg; // RQ2 RQ3
								fb_int_reg <= 1'b1; // RQ15
							end
						end
					end
					`TBCL_ADDR_VSEL: begin
						if (avs_byteenable[0]) begin
							vsel_reg <= avs_writedata[6:0] & `TBCL_VCODE_MAX; // RQ16
						end
					end
					`TBCL_ADDR_FREQ: begin
						if (avs_byteenable[0]) begin
							freq_half_reg[7:0] <= avs_writedata[7:0];
						end
						if (avs_byteenable[1]) begin
							freq_half_reg[15:8] <= avs_writedata[15:8];
						end
					end
					default: begin
						vsel_reg <= vsel_reg; // Read-only or unmapped: ignored
					end
				endcase
			end
		end
	end

	// Switching clock: internal half-period divider, or external
	// falling edges start each cycle when sync is selected
	wire hp_end = ({16'h0000, hp_cnt_reg} + 32'd1) >= {16'h0000, freq_half_reg};
	wire sync_fall = sync_d_reg & ~sync_s; // External falling edge
	always @(posedge clk_sys) begin
		if (!rstn) begin
			hp_cnt_reg <= 16'h0000;
			phase_reg <= 1'b0;
			ch1_clk_reg <= 1'b1;
			sync_d_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else if (ce) begin
			sync_d_reg <= sync_s;
			tick_reg <= 1'b0;
			if (sync_sel_reg & sync_fall) begin
				// Restart the cycle on the external edge
				hp_cnt_reg <= 16'h0000; // RQ11
				phase_reg <= 1'b1;
				ch1_clk_reg <= 1'b0; // RQ10
				tick_reg <= 1'b1;
			end else if (hp_end) begin
				hp_cnt_reg <= 16'h0000;
				if (phase_reg) begin
					phase_reg <= 1'b0;
					ch1_clk_reg <= 1'b1; // RQ10
				end else if (!sync_sel_reg) begin
					// Free running: self-start the next cycle
					phase_reg <= 1'b1;
					ch1_clk_reg <= 1'b0; // RQ10
					tick_reg <= 1'b1;
				end
			end else begin
				hp_cnt_reg <= hp_cnt_reg + 16'h0001;
			end
		end
	end

	// Thermal shutdown latched until the cool comparator reports
	always @(posedge clk_sys) begin
		if (!rstn) begin
			ot_reg <= 1'b0;
		end else if (ce) begin
			if (ott_s) begin
				ot_reg <= 1'b1;
			end else if (otc_s) begin
				ot_reg <= 1'b0; // RQ13
			end
		end
	end

	// Per-channel sequencer, protection and pin drive
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
			reg [2:0] st_reg; // One-hot state
			reg [8:0] oc_cnt_reg; // Overcurrent wait count
			reg [13:0] hic_cnt_reg; // Hiccup count
			reg run_reg; // Running output
			reg ss_reg; // Soft-start pulse
			reg hs_off_reg; // High-side off
			reg lx_low_reg; // Switch node low

			// Standalone ignores the host enables entirely
			wire en = bus_absent_reg ? on_s[gi] : (on_s[gi] & chan_en_reg[gi]); // RQ5 RQ6

			always @(posedge clk_sys) begin
				if (!rstn) begin
					st_reg <= ST_OFF;
					oc_cnt_reg <= 9'h000;
					hic_cnt_reg <= 14'h0000;
					run_reg <= 1'b0;
					ss_reg <= 1'b0;
					hs_off_reg <= 1'b1;
					lx_low_reg <= 1'b0;
				end else if (ce) begin
					ss_reg <= 1'b0;
					case (st_reg)
						ST_OFF: begin
							oc_cnt_reg <= 9'h000;
							if (en & ~ot_reg) begin
								st_reg <= ST_RUN;
								ss_reg <= 1'b1; // RQ13
							end
						end
						ST_RUN: begin
							if (~en | ot_reg) begin
								st_reg <= ST_OFF;
							end else if (~oc_s[gi]) begin
								oc_cnt_reg <= 9'h000; // RQ19
							end else if (tick_reg) begin
								// Overcurrent beyond the wait: hiccup
								if (oc_cnt_reg == `TBCL_OC_WAIT_CYC) begin
									st_reg <= ST_HIC; // RQ1
									hic_cnt_reg <= 14'h0000;
								end else begin
									oc_cnt_reg <= oc_cnt_reg + 9'h001;
								end
							end
						end
						ST_HIC: begin
							oc_cnt_reg <= 9'h000;
							if (~en | ot_reg) begin
								st_reg <= ST_OFF;
							end else if (tick_reg) begin
								if (hic_cnt_reg == HICCUP_CYCLES[13:0] - 14'h0001) begin
									st_reg <= ST_RUN; // RQ1
									ss_reg <= 1'b1; // RQ20
								end else begin
									hic_cnt_reg <= hic_cnt_reg + 14'h0001;
								end
							end
						end
						default: begin
							st_reg <= ST_OFF;
						end
					endcase
					run_reg <= (st_reg == ST_RUN) & en & ~ot_reg;
					// Switch held off while feedback stays high
					hs_off_reg <= ov_s[gi] | (st_reg != ST_RUN); // RQ12
					lx_low_reg <= buv_s[gi] & (st_reg == ST_RUN); // RQ14
				end
			end

			assign run_w[gi] = run_reg;
			assign oc_wait_w[gi] = (oc_cnt_reg != 9'h000);
			assign hic_w[gi] = (st_reg == ST_HIC);
			assign ch_run[gi] = run_reg;
			assign ss_start[gi] = ss_reg;
			assign hs_off[gi] = hs_off_reg;
			assign switch_node_low[gi] = lx_low_reg;
		end
	endgenerate

	// Skipping only when host allowed it and the bus is present
	always @(posedge clk_sys) begin
		if (!rstn) begin
			skip_out_reg <= 3'h0;
		end else if (ce) begin
			skip_out_reg <= skip_en_reg & {3{~bus_absent_reg}}; // RQ9
		end
	end

	// Power-good: every channel in window and sequence complete,
	// each direction filtered over its own count of switching cycles
	wire pg_target = (&pg_s) & (&ssd_s) & (&run_w); // RQ8
	wire [9:0] pg_limit = pok_reg ? `TBCL_PG_FALL_CYC : `TBCL_PG_RISE_CYC;
	always @(posedge clk_sys) begin
		if (!rstn) begin
			pok_reg <= 1'b0;
			pg_cnt_reg <= 10'h000;
		end else if (ce) begin
			if (pg_target == pok_reg) begin
				pg_cnt_reg <= 10'h000;
			end else if (tick_reg) begin
				if (pg_cnt_reg + 10'h001 >= pg_limit) begin
					pok_reg <= pg_target; // RQ17 RQ18
					pg_cnt_reg <= 10'h000;
				end else begin
					pg_cnt_reg <= pg_cnt_reg + 10'h001;
				end
			end
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = waitreq_reg;
	assign pulse_skip_setting = skip_out_reg;
	assign voltage_code = vcode_reg;
	assign fb_internal = fb_int_reg;
	assign sw_clk_ch1 = ch1_clk_reg;
	assign sw_clk_ch23 = phase_reg;
	assign power_ok_output = pok_reg;

endmodule
`default_nettype wire

// ---- testbench/tbcl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module tbcl_asserts (
	input wire clk_sys, // System clock
	input wire rstn, // Reset, active low
	input wire [1:0] avs_address, // Word address
	input wire avs_read, // Read request
	input wire avs_write, // Write request
	input wire [31:0] avs_writedata, // Write data
	input wire avs_waitrequest, // Stall
	input wire [2:0] ov_in, // Overvoltage pins
	input wire [2:0] bst_uv_in, // Bootstrap low pins
	input wire [2:0] pg_in, // Window pins
	input wire [2:0] ss_done_in, // Soft-start done pins
	input wire [2:0] ch_run, // Running channels
	input wire [2:0] ss_start, // Start pulses
	input wire [2:0] hs_off, // High-side held off
	input wire [2:0] switch_node_low, // Switch node pulled low
	input wire [6:0] voltage_code, // Active channel two code
	input wire fb_internal, // Internal divider chosen
	input wire sw_clk_ch1, // Channel one clock
	input wire sw_clk_ch23, // Channels two, three clock
	input wire power_ok_output // Power-good pin
);
	// Accepted control write with the trigger bit set
	wire go_acc = avs_write && !avs_waitrequest && avs_address == 2'h0 && avs_writedata[6];

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// Bus handshake: one wait state, then idle high again
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop after a request");
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest stayed low");
	// Clocks always in opposite phase, checked only outside reset
	a_phase_opp: assert property (sw_clk_ch1 != sw_clk_ch23)
		else $error("channel clocks not opposite");
	// Margin of five cycles covers the pin synchronisers
	a_hs_ov: assert property (ov_in[0] [*5] |=> hs_off[0])
		else $error("high side not held off on overvoltage");
	a_bst_low: assert property (!bst_uv_in[1] [*5] |=> !switch_node_low[1])
		else $error("switch node pulled without bootstrap low");
	// Every entry of channel one to run goes through a soft-start pulse
	a_run_start: assert property ($rose(ch_run[0]) |-> $past(ss_start[0]))
		else $error("channel ran without soft-start");
	a_start_pulse: assert property (ss_start[0] |=> !ss_start[0] && ch_run[0])
		else $error("soft-start pulse malformed");
	a_pok_rise: assert property ($rose(power_ok_output) |-> &{pg_in, ss_done_in, ch_run})
		else $error("power ok rose without all channels good");
	a_pok_fall: assert property ($fell(power_ok_output) |-> !(&{pg_in, ss_done_in, ch_run}))
		else $error("power ok fell with all channels good");
	// Voltage moves and divider switches in only on the trigger write
	a_code_go: assert property ($changed(voltage_code) |-> $past(go_acc))
		else $error("voltage code changed without trigger");
	a_fb_go: assert property ($rose(fb_internal) |-> $past(go_acc))
		else $error("divider switched without trigger");
endmodule

`default_nettype wire

// ---- testbench/tbcl_plant.sv ----
`timescale 1ns/10ps
`default_nettype none

module tbcl_plant (
	input wire clk_sys, // System clock
	input wire [2:0] ch_run, // Running channels
	input wire [2:0] pg_fault, // Push a channel out of window
	output logic [2:0] ss_done_in, // Soft-start finished
	output logic [2:0] pg_in // Output within window
);
	logic [2:0] ramp_reg = 3'h0; // Ramp stage per channel

	// Pins start quiet so nothing unknown reaches the synchronisers
	initial begin
		ss_done_in = 3'h0;
		pg_in = 3'h0;
	end

	// Ramp takes two cycles; a stopped channel drops out at once
	always @(posedge clk_sys) begin
		ramp_reg <= ch_run;
		ss_done_in <= ramp_reg & ch_run;
		pg_in <= ramp_reg & ch_run & ~pg_fault;
	end
endmodule

`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tbcl_defs.vh"

module tb_top;
	logic clk_sys = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0; // Clock, reset, strobes
	logic [1:0] avs_address = 2'h0; // Word address
	logic [31:0] avs_writedata = 32'h0, rd; // Write data, read back
	logic [2:0] chan_on = 3'h0, oc = 3'h0, ov = 3'h0, bootstrap_supply_pin = 3'h0, pg_fault = 3'h0; // Pins
	logic ot_trip = 1'h0, ot_cool = 1'h0, sync_in = 1'h0, bus_up = 1'h1; // Misc pins
	wire [31:0] avs_readdata; // Read data
	wire avs_waitrequest, fb_internal, sw_clk_ch1, sw_clk_ch23, power_ok_output; // Outputs
	wire [2:0] ch_run, ss_start, hs_off, switch_node_low, pulse_skip_setting; // Channel outputs
	wire [2:0] pg_in, ss_done_in; // From plant
	wire [6:0] voltage_code; // Active code
	int err_total = 0, checked = 0, seed = 21, n, code, act = 0; // Counters, model
	longint t0; // Edge time

	always #25 clk_sys = ~clk_sys;
	// External clock at 400 ns, offset so it never meets a clock edge
	initial begin
		#13;
		forever #200 sync_in = ~sync_in;
	end

	// Short hiccup keeps the run brief
	tbcl_top #(.HICCUP_CYCLES(16)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'h1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .channel_on_input(chan_on), .oc_in(oc),
		.ov_in(ov), .bst_uv_in(bootstrap_supply_pin), .pg_in(pg_in), .ss_done_in(ss_done_in),
		.ot_trip_in(ot_trip), .ot_cool_in(ot_cool), .sync_in(sync_in), .scl_in(bus_up),
		.sda_in(bus_up), .ch_run(ch_run), .ss_start(ss_start), .hs_off(hs_off),
		.switch_node_low(switch_node_low), .pulse_skip_setting(pulse_skip_setting),
		.voltage_code(voltage_code), .fb_internal(fb_internal), .sw_clk_ch1(sw_clk_ch1),
		.sw_clk_ch23(sw_clk_ch23), .power_ok_output(power_ok_output));

	tbcl_plant u_plant (.clk_sys(clk_sys), .ch_run(ch_run), .pg_fault(pg_fault),
		.ss_done_in(ss_done_in), .pg_in(pg_in));

	// Verdict and end of run
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Value comparison
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One bus access; held until waitrequest is seen low
	task bus(input logic we, input logic [1:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= we;
		avs_read <= !we;
		avs_writedata <= d;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (avs_waitrequest !== 1'h0 && t < 20);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (t >= 20) chk("handshake", 32'h0, 32'h1);
		// One more edge so the accepting edge's updates are visible
		@(posedge clk_sys);
	endtask

	// Wait whole switching cycles, end on a clock edge
	task ticks(input int k);
		repeat (k) @(posedge sw_clk_ch23);
		@(posedge clk_sys);
	endtask

	// Hang guard
	initial begin
		#3000000;
		err_total++;
		wrap_up;
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'h1;
		bus(0, `TBCL_ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h7, rd);
		bus(0, `TBCL_ADDR_FREQ, 32'h0);
		chk("freq reset", 32'h14, rd);
		bus(1, `TBCL_ADDR_FREQ, 32'h2);
		chk("fb reset", 32'h0, fb_internal);
		// Codes at both ends and one random in between
		for (n = 0; n < 3; n++) begin
			code = (n == 0) ? 127 : (n == 1) ? ($random(seed) & 127) : 0;
			bus(1, `TBCL_ADDR_VSEL, code);
			chk("code held", act, voltage_code);
			bus(1, `TBCL_ADDR_CTRL, 32'h47);
			act = code;
			chk("code", act, voltage_code);
			chk("fb internal", 32'h1, fb_internal);
			bus(0, `TBCL_ADDR_VSEL, 32'h0);
			chk("vsel", ((680 + 10 * act) << 16) | 32'h80 | act, rd);
		end
		chk("skip default", 32'h0, pulse_skip_setting);
		bus(1, `TBCL_ADDR_CTRL, 32'h2F);
		ticks(1);
		chk("skip", 32'h5, pulse_skip_setting);
		bus(1, `TBCL_ADDR_CTRL, 32'h07);
		chan_on <= 3'h7;
		ticks(10);
		chk("run all", 32'h7, ch_run);
		bus(1, `TBCL_ADDR_CTRL, 32'h05);
		ticks(2);
		chk("run masked", 32'h5, ch_run);
		bus(0, `TBCL_ADDR_STAT, 32'h0);
		chk("stat run", 32'h5, rd[6:4]);
		bus(1, `TBCL_ADDR_CTRL, 32'h07);
		// Power ok deglitch in both directions
		ticks(600);
		chk("pok early", 32'h0, power_ok_output);
		ticks(25);
		chk("pok", 32'h1, power_ok_output);
		bus(0, `TBCL_ADDR_STAT, 32'h0);
		chk("stat pok", 32'hF, rd[3:0]);
		pg_fault <= 3'h1;
		ticks(105);
		chk("pok held", 32'h1, power_ok_output);
		ticks(15);
		chk("pok fall", 32'h0, power_ok_output);
		pg_fault <= 3'h0;
		n = $random(seed) & 7;
		ov <= n;
		bootstrap_supply_pin <= n;
		ticks(2);
		chk("hs off", n, hs_off);
		chk("node low", n, switch_node_low);
		ov <= 3'h0;
		bootstrap_supply_pin <= 3'h0;
		ticks(2);
		chk("hs on", 32'h0, hs_off);
		// Broken overcurrent must not add up, unbroken must
		oc <= 3'h4;
		ticks(200);
		oc <= 3'h0;
		ticks(2);
		oc <= 3'h4;
		ticks(250);
		chk("oc wait", 32'h7, ch_run);
		ticks(12);
		chk("hiccup", 32'h3, ch_run);
		oc <= 3'h0;
		ticks(20);
		chk("restart", 32'h7, ch_run);
		ot_trip <= 1'h1;
		ticks(3);
		chk("thermal off", 32'h0, ch_run);
		ot_trip <= 1'h0;
		ot_cool <= 1'h1;
		ticks(3);
		chk("thermal on", 32'h7, ch_run);
		ot_cool <= 1'h0;
		// Locked to the falling edge of the external clock
		bus(1, `TBCL_ADDR_CTRL, 32'h87);
		ticks(4);
		@(negedge sync_in);
		t0 = $time;
		@(posedge sw_clk_ch23);
		chk("sync lag", 32'h1, ($time - t0) < 250);
		t0 = $time;
		@(posedge sw_clk_ch23);
		chk("sync period", 32'd400, $time - t0);
		// Bus lines low: standalone
		bus_up <= 1'h0;
		ticks(2);
		bus(1, `TBCL_ADDR_CTRL, 32'h0);
		bus(0, `TBCL_ADDR_CTRL, 32'h0);
		chk("absent read", 32'h0, rd);
		chk("absent fb", 32'h0, fb_internal);
		chan_on <= 3'h2;
		ticks(3);
		chk("pin only", 32'h2, ch_run);
		wrap_up;
	end
endmodule

bind tbcl_top tbcl_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .ov_in(ov_in), .bst_uv_in(bst_uv_in), .pg_in(pg_in),
	.ss_done_in(ss_done_in), .ch_run(ch_run), .ss_start(ss_start), .hs_off(hs_off),
	.switch_node_low(switch_node_low), .voltage_code(voltage_code),
	.fb_internal(fb_internal), .sw_clk_ch1(sw_clk_ch1), .sw_clk_ch23(sw_clk_ch23),
	.power_ok_output(power_ok_output));

`default_nettype wire
